// File: watchdog_timer_unit.sv
// watchdog timer unit with AXI4-Lite register access
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module watchdog_timer_unit #(
  parameter int RC_CYCLES = watchdog_pkg::RC_TICK_CYCLES
) (
  input  wire logic                                ref_clk,
  input  wire logic                                reset,
  input  wire logic                                ce,
  input  wire logic [7:0]                          optionByteThree,
  input  wire logic                                chipResetIn,
  input  wire logic [watchdog_pkg::CAUSE_EVT_W-1:0] causeEvents,
  input  wire logic [watchdog_pkg::ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic                                s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire logic [31:0]                         s_axi_wdata,
  input  wire logic [3:0]                          s_axi_wstrb,
  input  wire logic                                s_axi_wvalid,
  output logic                                     s_axi_wready,
  output logic [1:0]                               s_axi_bresp,
  output logic                                     s_axi_bvalid,
  input  wire logic                                s_axi_bready,
  input  wire logic [watchdog_pkg::ADDR_W-1:0]      s_axi_araddr,
  input  wire logic                                s_axi_arvalid,
  output logic                                     s_axi_arready,
  output logic [31:0]                              s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  output logic                                     s_axi_rvalid,
  input  wire logic                                s_axi_rready,
  output logic                                     chipResetReq,
  output logic                                     dogIrq,
  output logic                                     dogRunning
);
  logic                              awReady_r;
  logic                              awHeld_r;
  logic [watchdog_pkg::ADDR_W-1:0]   awAddr_r;
  logic                              wReady_r;
  logic                              wHeld_r;
  logic [7:0]                        wByte_r;
  logic                              wLane_r;
  logic                              bValid_r;
  logic [1:0]                        bResp_r;
  logic                              arReady_r;
  logic                              rValid_r;
  logic [7:0]                        rByte_r;
  logic [1:0]                        rResp_r;

  watchdog_pkg::ctrl_t               ctrl_r;
  logic [watchdog_pkg::COUNT_W-1:0]  count_r;
  logic [7:0]                        cause_r;
  logic                              irqFlag_r;
  logic                              chipResetReq_r;

  logic                              writeCommit;
  logic [7:0]                        writeIdx;
  logic                              writeLive;
  logic                              ctrlWrite;
  logic                              keyWrite;
  logic                              refresh;
  logic                              unlocked;
  logic                              dogActive;
  logic                              divTick;
  logic                              overflow;
  logic                              overflowReset;
  logic                              overflowIrq;
  logic                              prescaleRestart;
  logic [7:0]                        causeSet;
  logic [7:0]                        causeKeep;

  function automatic logic [7:0] regIdx(input logic [watchdog_pkg::ADDR_W-1:0] addr);
    regIdx = addr[watchdog_pkg::ADDR_W-1:2];
  endfunction

  function automatic logic isMapped(input logic [7:0] idx);
    isMapped = (idx == watchdog_pkg::RESET_CAUSE_IDX) || (idx == watchdog_pkg::CONTROL_IDX) ||
               (idx == watchdog_pkg::REFRESH_KEY_IDX) || (idx == watchdog_pkg::TIMED_KEY_IDX) ||
               (idx == watchdog_pkg::IRQ_REQ_TWO_IDX);
  endfunction

  function automatic logic [7:0] ctrlByte(input watchdog_pkg::ctrl_t c);
    ctrlByte = 8'h00;
    ctrlByte[watchdog_pkg::CTRL_ACTION_BIT] = c.action;
    ctrlByte[watchdog_pkg::CTRL_ENABLE_BIT] = c.enable;
    ctrlByte[watchdog_pkg::CTRL_DIV_LSB +: watchdog_pkg::DIV_W] = c.divSel;
  endfunction

  // write channel: address and data taken in either order
  assign writeCommit = awHeld_r && wHeld_r && !bValid_r;
  assign writeIdx    = regIdx(awAddr_r);
  assign writeLive   = writeCommit && wLane_r;
  assign ctrlWrite   = writeLive && (writeIdx == watchdog_pkg::CONTROL_IDX) && unlocked;
  assign keyWrite    = writeLive && (writeIdx == watchdog_pkg::TIMED_KEY_IDX);
  assign refresh     = writeLive && (writeIdx == watchdog_pkg::REFRESH_KEY_IDX) &&
                       (wByte_r == watchdog_pkg::REFRESH_KEY);

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      awReady_r <= 1'b1;
      awHeld_r  <= 1'b0;
      awAddr_r  <= 10'h000;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && awReady_r)
      begin
        awReady_r <= 1'b0;
        awHeld_r  <= 1'b1;
        awAddr_r  <= s_axi_awaddr;
      end
      else if (writeCommit)
        awHeld_r <= 1'b0;
      else if (bValid_r && s_axi_bready)
        awReady_r <= 1'b1;
    end

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      wReady_r <= 1'b1;
      wHeld_r  <= 1'b0;
      wByte_r  <= 8'h00;
      wLane_r  <= 1'b0;
    end
    else if (ce)
    begin
      if (s_axi_wvalid && wReady_r)
      begin
        wReady_r <= 1'b0;
        wHeld_r  <= 1'b1;
        wByte_r  <= s_axi_wdata[7:0];
        wLane_r  <= s_axi_wstrb[0];
      end
      else if (writeCommit)
        wHeld_r <= 1'b0;
      else if (bValid_r && s_axi_bready)
        wReady_r <= 1'b1;
    end

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      bValid_r <= 1'b0;
      bResp_r  <= watchdog_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (writeCommit)
      begin
        bValid_r <= 1'b1;
        bResp_r  <= isMapped(writeIdx) ? watchdog_pkg::RESP_OKAY : watchdog_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        bValid_r <= 1'b0;
    end

  // read channel: one read at a time, data one cycle after address
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      arReady_r <= 1'b1;
      rValid_r  <= 1'b0;
      rByte_r   <= 8'h00;
      rResp_r   <= watchdog_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && arReady_r)
      begin
        arReady_r <= 1'b0;
        rValid_r  <= 1'b1;
        rResp_r   <= isMapped(regIdx(s_axi_araddr)) ? watchdog_pkg::RESP_OKAY : watchdog_pkg::RESP_SLVERR;
        case (regIdx(s_axi_araddr))
          watchdog_pkg::RESET_CAUSE_IDX: rByte_r <= cause_r;
          watchdog_pkg::CONTROL_IDX:     rByte_r <= ctrlByte(ctrl_r);
          watchdog_pkg::IRQ_REQ_TWO_IDX: rByte_r <= {6'h00, irqFlag_r, 1'b0};
          default:                       rByte_r <= 8'h00;
        endcase
      end
      else if (rValid_r && s_axi_rready)
      begin
        rValid_r  <= 1'b0;
        arReady_r <= 1'b1;
      end
    end

  dog_key_unlock keyUnlock (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .ce        (ce),
    .keyWrite  (keyWrite),
    .keyByte   (wByte_r),
    .ctrlWrite (ctrlWrite),
    .unlocked  (unlocked)
  );

  // counting and time-out
  assign dogActive       = ctrl_r.enable && !optionByteThree[watchdog_pkg::FUSE_BIT];
  assign overflow        = dogActive && divTick && (count_r == watchdog_pkg::COUNT_MAX);
  assign overflowReset   = overflow && !ctrl_r.action;
  assign overflowIrq     = overflow && ctrl_r.action;
  assign prescaleRestart = refresh || !dogActive || chipResetIn;

  dog_prescaler #(
    .RC_CYCLES (RC_CYCLES)
  ) prescaler (
    .ref_clk (ref_clk),
    .reset   (reset),
    .ce      (ce),
    .restart (prescaleRestart),
    .divSel  (ctrl_r.divSel),
    .divTick (divTick)
  );

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      count_r <= 8'h00;
    else if (ce)
    begin
      if (chipResetIn || !dogActive || refresh)
        count_r <= 8'h00;
      else if (divTick)
        count_r <= count_r + 8'h01;
    end

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      ctrl_r <= '{action: watchdog_pkg::CONTROL_RESET[watchdog_pkg::CTRL_ACTION_BIT],
                  enable: watchdog_pkg::CONTROL_RESET[watchdog_pkg::CTRL_ENABLE_BIT],
                  divSel: watchdog_pkg::CONTROL_RESET[watchdog_pkg::CTRL_DIV_LSB +: watchdog_pkg::DIV_W]};
    else if (ce)
    begin
      if (chipResetIn || overflowReset)
        ctrl_r.enable <= 1'b0;
      else if (ctrlWrite)
      begin
        ctrl_r.action <= wByte_r[watchdog_pkg::CTRL_ACTION_BIT];
        ctrl_r.divSel <= wByte_r[watchdog_pkg::CTRL_DIV_LSB +: watchdog_pkg::DIV_W];
        // a running watchdog keeps its enable set
        ctrl_r.enable <= wByte_r[watchdog_pkg::CTRL_ENABLE_BIT] || dogActive;
      end
    end

  // reset cause flags: hardware set wins over software clear
  assign causeSet  = {3'h0, causeEvents} | (8'(overflowReset) << watchdog_pkg::CAUSE_DOG_BIT);
  assign causeKeep = (writeLive && writeIdx == watchdog_pkg::RESET_CAUSE_IDX) ? wByte_r : 8'hff;

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      cause_r <= watchdog_pkg::CAUSE_RESET;
    else if (ce)
      cause_r <= ((cause_r & causeKeep) | causeSet) & watchdog_pkg::CAUSE_MASK;

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      irqFlag_r <= 1'b0;
    else if (ce)
    begin
      if (overflowIrq)
        irqFlag_r <= 1'b1;
      else if (writeLive && writeIdx == watchdog_pkg::IRQ_REQ_TWO_IDX && !wByte_r[watchdog_pkg::IRQ_DOG_BIT])
        irqFlag_r <= 1'b0;
    end

  // reset request pulse, registered one cycle after the overflow
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      chipResetReq_r <= 1'b0;
    else if (ce)
      chipResetReq_r <= overflowReset;

  assign s_axi_awready = awReady_r;
  assign s_axi_wready  = wReady_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = {24'h000000, rByte_r};
  assign s_axi_rresp   = rResp_r;
  assign chipResetReq  = chipResetReq_r;
  assign dogIrq        = irqFlag_r;
  assign dogRunning    = ctrl_r.enable;

  count_advance_a : assert property (@(posedge ref_clk) disable iff (reset)
    (ce && dogActive && divTick && !refresh && !chipResetIn && count_r != watchdog_pkg::COUNT_MAX)
    |=> (count_r == $past(count_r) + 8'h01))
    else $error("counter did not advance on a divided tick");

  refresh_clear_a : assert property (@(posedge ref_clk) disable iff (reset)
    (ce && refresh) |=> (count_r == 8'h00))
    else $error("refresh key did not clear the counter");

  overflow_reset_a : assert property (@(posedge ref_clk) disable iff (reset)
    (ce && overflowReset) |=> (chipResetReq_r && cause_r[watchdog_pkg::CAUSE_DOG_BIT] && !ctrl_r.enable))
    else $error("overflow in reset mode missed request, flag or enable clear");

  overflow_irq_a : assert property (@(posedge ref_clk) disable iff (reset)
    (ce && overflowIrq) |=> (irqFlag_r && !chipResetReq_r && count_r == 8'h00))
    else $error("overflow in interrupt mode handled wrongly");

  fuse_hold_a : assert property (@(posedge ref_clk) disable iff (reset)
    (ce && optionByteThree[watchdog_pkg::FUSE_BIT]) |=> (count_r == 8'h00 && !chipResetReq_r))
    else $error("watchdog counted while the fuse holds it off");

  ctrl_locked_a : assert property (@(posedge ref_clk) disable iff (reset)
    (ce && writeLive && writeIdx == watchdog_pkg::CONTROL_IDX && !unlocked && !chipResetIn && !overflowReset)
    |=> $stable(ctrl_r))
    else $error("control register changed without the key sequence");

  no_halt_a : assert property (@(posedge ref_clk) disable iff (reset)
    (ce && dogActive && !overflowReset && !chipResetIn) |=> ctrl_r.enable)
    else $error("running watchdog was halted");

  reset_pulse_a : assert property (@(posedge ref_clk) disable iff (reset)
    (ce && chipResetReq_r) |=> !chipResetReq_r)
    else $error("reset request longer than one cycle");

  flag_sticky_a : assert property (@(posedge ref_clk) disable iff (reset)
    (cause_r[watchdog_pkg::CAUSE_DOG_BIT] && !(writeLive && writeIdx == watchdog_pkg::RESET_CAUSE_IDX))
    |=> cause_r[watchdog_pkg::CAUSE_DOG_BIT])
    else $error("watchdog reset flag lost without a software clear");

  bresp_hold_a : assert property (@(posedge ref_clk) disable iff (reset)
    (bValid_r && !s_axi_bready) |=> bValid_r)
    else $error("write response dropped before it was taken");

  enable_clear_a : assert property (@(posedge ref_clk) disable iff (reset)
    (ce && chipResetIn) |=> !ctrl_r.enable)
    else $error("chip reset left the watchdog enabled");
endmodule // watchdog_timer_unit

// File: watchdog_pkg.sv
// constants and types shared by the watchdog timer unit
package watchdog_pkg;
  localparam int CLK_PERIOD_NS  = 8;
  localparam int RC_FREQ_HZ     = 23000;
  localparam int RC_PERIOD_NS   = 1000000000 / RC_FREQ_HZ;
  localparam int RC_TICK_CYCLES = RC_PERIOD_NS / CLK_PERIOD_NS;

  localparam int ADDR_W      = 10;
  localparam int COUNT_W     = 8;
  localparam int DIV_W       = 4;
  localparam int PRESCALE_W  = 15;
  localparam int RC_CNT_W    = 16;
  localparam int CAUSE_EVT_W = 5;

  localparam logic [7:0] RESET_CAUSE_IDX  = 8'ha1;
  localparam logic [7:0] CONTROL_IDX      = 8'hb6;
  localparam logic [7:0] REFRESH_KEY_IDX  = 8'hb7;
  localparam logic [7:0] TIMED_KEY_IDX    = 8'hf7;
  localparam logic [7:0] IRQ_REQ_TWO_IDX  = 8'h97;

  localparam int CTRL_ACTION_BIT = 6;
  localparam int CTRL_ENABLE_BIT = 5;
  localparam int CTRL_DIV_LSB    = 0;
  localparam int CAUSE_DOG_BIT   = 3;
  localparam int IRQ_DOG_BIT     = 1;
  localparam int FUSE_BIT        = 7;

  localparam logic [7:0] CONTROL_RESET = 8'h04;
  localparam logic [7:0] CAUSE_RESET   = 8'h00;
  localparam logic [7:0] CAUSE_MASK    = 8'h1f;
  localparam logic [7:0] REFRESH_KEY   = 8'h55;
  localparam logic [7:0] KEY_FIRST     = 8'h55;
  localparam logic [7:0] KEY_SECOND    = 8'haa;
  localparam logic [7:0] KEY_THIRD     = 8'h5a;
  localparam logic [7:0] COUNT_MAX     = 8'hff;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic             action;
    logic             enable;
    logic [DIV_W-1:0] divSel;
  } ctrl_t;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_GOT1 = 2'b01,
    KEY_GOT2 = 2'b10,
    KEY_OPEN = 2'b11
  } key_state_t;
endpackage

// File: dog_prescaler.sv
// slow oscillator tick and power-of-two divider for the watchdog
`timescale 1ns/100ps
module dog_prescaler #(
  parameter int RC_CYCLES = watchdog_pkg::RC_TICK_CYCLES
) (
  input  wire logic                          ref_clk,
  input  wire logic                          reset,
  input  wire logic                          ce,
  input  wire logic                          restart,
  input  wire logic [watchdog_pkg::DIV_W-1:0] divSel,
  output logic                               divTick
);
  logic [watchdog_pkg::RC_CNT_W-1:0]   rcCnt_r;
  logic [watchdog_pkg::PRESCALE_W-1:0] pre_r;
  logic                                rcTick;

  function automatic logic [watchdog_pkg::PRESCALE_W-1:0] divMask(input logic [watchdog_pkg::DIV_W-1:0] sel);
    logic [watchdog_pkg::RC_CNT_W-1:0] one;
    one     = 16'h0001 << sel;
    divMask = 15'(one - 16'h0001);
  endfunction

  assign rcTick = (rcCnt_r == 16'(RC_CYCLES - 1));

  // free running oscillator stand-in, never restarted
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      rcCnt_r <= 16'h0000;
    else if (ce)
      rcCnt_r <= rcTick ? 16'h0000 : rcCnt_r + 16'h0001;

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      pre_r <= 15'h0000;
    else if (ce)
    begin
      if (restart)
        pre_r <= 15'h0000;
      else if (rcTick)
        pre_r <= pre_r + 15'h0001;
    end

  // one divided tick every two to the divSel oscillator ticks
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      divTick <= 1'b0;
    else if (ce)
      divTick <= !restart && rcTick && ((pre_r & divMask(divSel)) == divMask(divSel));

  tick_spacing_a : assert property (@(posedge ref_clk) disable iff (reset)
    (ce && rcTick) |=> !rcTick)
    else $error("oscillator tick repeated on consecutive cycles");
endmodule // dog_prescaler

// File: dog_key_unlock.sv
// timed-access key sequence that opens one control write
`timescale 1ns/100ps
module dog_key_unlock (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic       keyWrite,
  input  wire logic [7:0] keyByte,
  input  wire logic       ctrlWrite,
  output logic            unlocked
);
  watchdog_pkg::key_state_t state_r;
  watchdog_pkg::key_state_t state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      watchdog_pkg::KEY_IDLE,
      watchdog_pkg::KEY_OPEN:
        if (state_r == watchdog_pkg::KEY_OPEN && ctrlWrite)
          state_nxt = watchdog_pkg::KEY_IDLE;
        else if (keyWrite)
          state_nxt = (keyByte == watchdog_pkg::KEY_FIRST) ? watchdog_pkg::KEY_GOT1 : watchdog_pkg::KEY_IDLE;
      watchdog_pkg::KEY_GOT1:
        if (keyWrite)
        begin
          if (keyByte == watchdog_pkg::KEY_SECOND)
            state_nxt = watchdog_pkg::KEY_GOT2;
          else
            state_nxt = (keyByte == watchdog_pkg::KEY_FIRST) ? watchdog_pkg::KEY_GOT1 : watchdog_pkg::KEY_IDLE;
        end
      watchdog_pkg::KEY_GOT2:
        if (keyWrite)
        begin
          if (keyByte == watchdog_pkg::KEY_THIRD)
            state_nxt = watchdog_pkg::KEY_OPEN;
          else
            state_nxt = (keyByte == watchdog_pkg::KEY_FIRST) ? watchdog_pkg::KEY_GOT1 : watchdog_pkg::KEY_IDLE;
        end
      default:
        state_nxt = watchdog_pkg::KEY_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      state_r <= watchdog_pkg::KEY_IDLE;
    else if (ce)
      state_r <= state_nxt;

  assign unlocked = (state_r == watchdog_pkg::KEY_OPEN);

  key_open_a : assert property (@(posedge ref_clk) disable iff (reset)
    (ce && keyWrite && keyByte == watchdog_pkg::KEY_THIRD && state_r == watchdog_pkg::KEY_GOT2) |=> unlocked)
    else $error("key sequence did not open the control register");
endmodule // dog_key_unlock

// File: watchdog_timer_unit_bench.sv
// self-checking bench for the watchdog timer unit
`timescale 1ns/100ps
module watchdog_timer_unit_bench;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        chipResetIn = 1'b0;
  logic [7:0]  optionByteThree = 8'h00;
  logic [9:0]  awaddr = 10'h000;
  logic [9:0]  araddr = 10'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0]  wstrb = 4'h1;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        arvalid = 1'b0;
  logic        bready = 1'b1;
  logic        rready = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid, chipResetReq, dogIrq, dogRunning;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rd;
  int          n_fail = 0;
  int          checks = 0;
  int          nRst = 0;
  int          base;

  watchdog_timer_unit #(.RC_CYCLES(4)) uut (.ref_clk(ref_clk), .reset(reset), .ce(1'b1),
    .optionByteThree(optionByteThree), .chipResetIn(chipResetIn), .causeEvents(5'h00),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .chipResetReq(chipResetReq), .dogIrq(dogIrq), .dogRunning(dogRunning));

  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) if (chipResetReq === 1'b1) nRst <= nRst + 1;

  task automatic conclude();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    resp = bresp;
  endtask

  task automatic rdreg(input logic [7:0] idx);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
  endtask

  task automatic keys();
    wr(watchdog_pkg::TIMED_KEY_IDX, 8'h55);
    wr(watchdog_pkg::TIMED_KEY_IDX, 8'haa);
    wr(watchdog_pkg::TIMED_KEY_IDX, 8'h5a);
  endtask

  task automatic pulse();
    chipResetIn <= 1'b1;
    @(posedge ref_clk);
    chipResetIn <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic t_reset();
    rdreg(watchdog_pkg::CONTROL_IDX);
    chk("control", 32'h04, rd);
    chk("control resp", {30'h0, watchdog_pkg::RESP_OKAY}, {30'h0, resp});
    rdreg(watchdog_pkg::RESET_CAUSE_IDX);
    chk("cause", 32'h00, rd);
    chk("running", 32'h0, {31'h0, dogRunning});
    rdreg(8'h00);
    chk("unmapped resp", {30'h0, watchdog_pkg::RESP_SLVERR}, {30'h0, resp});
    wr(8'h00, 8'h55);
    chk("unmapped write resp", {30'h0, watchdog_pkg::RESP_SLVERR}, {30'h0, resp});
  endtask

  task automatic t_lock();
    wr(watchdog_pkg::CONTROL_IDX, 8'h24);
    chk("locked resp", {30'h0, watchdog_pkg::RESP_OKAY}, {30'h0, resp});
    rdreg(watchdog_pkg::CONTROL_IDX);
    chk("locked control", 32'h04, rd);
    wr(watchdog_pkg::TIMED_KEY_IDX, 8'h55);
    wr(watchdog_pkg::TIMED_KEY_IDX, 8'haa);
    wr(watchdog_pkg::TIMED_KEY_IDX, 8'h00);
    wr(watchdog_pkg::TIMED_KEY_IDX, 8'h5a);
    wr(watchdog_pkg::CONTROL_IDX, 8'h24);
    rdreg(watchdog_pkg::CONTROL_IDX);
    chk("broken keys", 32'h04, rd);
    keys();
    wr(watchdog_pkg::CONTROL_IDX, 8'h44);
    wr(watchdog_pkg::CONTROL_IDX, 8'h04);
    rdreg(watchdog_pkg::CONTROL_IDX);
    chk("one write only", 32'h44, rd);
  endtask

  task automatic t_run();
    keys();
    wr(watchdog_pkg::CONTROL_IDX, 8'h20);
    rdreg(watchdog_pkg::CONTROL_IDX);
    chk("enabled control", 32'h20, rd);
    chk("running", 32'h1, {31'h0, dogRunning});
    keys();
    wr(watchdog_pkg::CONTROL_IDX, 8'h00);
    rdreg(watchdog_pkg::CONTROL_IDX);
    chk("no halt", 32'h20, rd);
    rdreg(watchdog_pkg::REFRESH_KEY_IDX);
    chk("refresh reads", 32'h00, rd);
    base = nRst;
    repeat (700) @(posedge ref_clk);
    wr(watchdog_pkg::REFRESH_KEY_IDX, 8'h55);
    repeat (1000) @(posedge ref_clk);
    chk("early reset", base, nRst);
    for (int i = 0; i < 100 && nRst == base; i++) @(posedge ref_clk);
    chk("overflow reset", base + 1, nRst);
    rdreg(watchdog_pkg::RESET_CAUSE_IDX);
    chk("dog flag", 32'h08, rd);
    pulse();
    chk("cleared enable", 32'h0, {31'h0, dogRunning});
    rdreg(watchdog_pkg::RESET_CAUSE_IDX);
    chk("flag kept", 32'h08, rd);
    wr(watchdog_pkg::RESET_CAUSE_IDX, 8'h00);
    rdreg(watchdog_pkg::RESET_CAUSE_IDX);
    chk("flag cleared", 32'h00, rd);
  endtask

  task automatic t_irq();
    base = nRst;
    keys();
    wr(watchdog_pkg::CONTROL_IDX, 8'h61);
    repeat (1900) @(posedge ref_clk);
    chk("early irq", 32'h0, {31'h0, dogIrq});
    for (int i = 0; i < 400 && dogIrq !== 1'b1; i++) @(posedge ref_clk);
    chk("irq", 32'h1, {31'h0, dogIrq});
    chk("no reset", base, nRst);
    rdreg(watchdog_pkg::IRQ_REQ_TWO_IDX);
    chk("irq reg", 32'h02, rd);
    wr(watchdog_pkg::IRQ_REQ_TWO_IDX, 8'h00);
    rdreg(watchdog_pkg::IRQ_REQ_TWO_IDX);
    chk("irq cleared", 32'h00, rd);
    chk("irq mode running", 32'h1, {31'h0, dogRunning});
    pulse();
    chk("reset clears enable", 32'h0, {31'h0, dogRunning});
  endtask

  task automatic t_fuse();
    optionByteThree <= 8'h80;
    base = nRst;
    keys();
    wr(watchdog_pkg::CONTROL_IDX, 8'h20);
    rdreg(watchdog_pkg::CONTROL_IDX);
    chk("fused control", 32'h20, rd);
    repeat (1200) @(posedge ref_clk);
    chk("fused reset", base, nRst);
  endtask

  initial
  begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_lock();
    t_run();
    t_irq();
    t_fuse();
    conclude();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    conclude();
  end
endmodule // watchdog_timer_unit_bench
